// ==== verilog/psa_consts.svh ====
// psa_consts.svh: register offsets, field positions, reset values, timing counts
// assumes: included by bare name from the arbiter design files
//
// Overview of operation
// R1: Accepted ON runs off-to-active sequence
// R2: ON ignored while any gate holds
// R3: Overtemperature gates every ON, never masked
// R4: Enabled interrupt events also act as ON
// R5: OFF from active or sleep, matching sequence
// R6: OFF wins over ON and SLEEP, ungated
// R7: After OFF, ON waits for request removal
// R8: One switch-off delay: 0,1,2,4 seconds
// R9: Each OFF selects hard or soft reset
// R10: Shutdown OFF stays in OFF state
// R11: Cold restart reaches OFF, then restarts unless a gate holds
// R12: Watchdog off at reset, lockable, timeout means OFF
// R13: Keep bit and keep pin both low: OFF, only once either was high in active
// R14: SLEEP request moves active into sleep
// R15: SLEEP blocked by pending unmasked interrupt
// R16: In sleep only interrupt or pin wake
// R17: WAKE only in sleep, to active or off
// R18: Only five power transitions allowed
// R19: Arbitration paced by 32 kHz tick
// R20: Button, keep and sleep pin levels debounced on slow tick; off pin level used raw; ON takes the raw button level, the filtered one only feeds OFF
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define PSA_REG_CTRL 8'h00
`define PSA_REG_CFG 8'h04
`define PSA_REG_WDOG 8'h08
`define PSA_REG_STATUS 8'h0C
`define PSA_REG_RST 32'h00000000

// ----------------------------------------
// field positions
// ----------------------------------------
`define PSA_CTRL_KEEP_BIT 0
`define PSA_CTRL_RESTART_BIT 1
`define PSA_CFG_DLY_LSB 0
`define PSA_CFG_HARD_BIT 2
`define PSA_CFG_RESTART_BIT 3
`define PSA_CFG_SLEEP_EN_BIT 4
`define PSA_CFG_ADC_EN_BIT 5
`define PSA_CFG_OFFPOL_BIT 6
`define PSA_CFG_IRQ_LSB 8
`define PSA_WDOG_EN_BIT 0
`define PSA_WDOG_LOCK_BIT 1

// ----------------------------------------
// power state codes
// ----------------------------------------
`define PSA_PS_OFF 2'h0
`define PSA_PS_ACTIVE 2'h1
`define PSA_PS_SLEEP 2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define PSA_CLK_HZ 100000000
`define PSA_SLOW_HZ 32000
`define PSA_SLOW_DIV (`PSA_CLK_HZ / `PSA_SLOW_HZ)
`define PSA_KEEP_DB_MS 4
`define PSA_KEEP_DB_TICKS ((`PSA_KEEP_DB_MS * `PSA_SLOW_HZ + 999) / 1000)
`define PSA_SLEEP_DB_TICKS 2
`define PSA_SWOFF_UNIT_S 1
`define PSA_LONG_PRESS_S 8

`endif

// ==== verilog/psa_pkg.sv ====
// psa_pkg: state, sequence and register-image types of the arbiter
// assumes: compiled before every arbiter module
package psa_pkg;

typedef enum logic [2:0] {
    psa_st_off, psa_st_act, psa_st_slp, psa_st_dly, psa_st_seq
} psa_state_type;

typedef enum logic [2:0] {
    psa_q_none, psa_q_off_act, psa_q_act_off, psa_q_act_slp, psa_q_slp_act, psa_q_slp_off
} psa_seq_type;

typedef struct packed {
    logic level;
    logic [19:0] cnt;
} psa_deb_type;

typedef struct packed {
    psa_state_type st;
    logic [1:0] pstate;
    psa_seq_type kind;
    logic seq_start;
    logic rst_req;
    logic rst_hard;
    logic [19:0] dly;
    logic off_restart;
    logic off_block;
    logic hold_armed;
    logic [7:0] irq_evt;
    logic [11:0] div;
    logic tick;
    logic keep_on;
    logic restart_req;
    logic [1:0] dly_sel;
    logic cfg_hard;
    logic cfg_restart;
    logic sleep_en;
    logic adc_en;
    logic offpin_pol;
    logic [7:0] irq_on_en;
    logic wd_en;
    logic wd_lock;
    logic rd_ok;
    logic [31:0] prdata;
} psa_main_type;

endpackage

// ==== verilog/psa_debounce.sv ====
// psa_debounce: one pin level filter counted in slow ticks
// assumes: tick is a one-cycle pulse, raw synchronous to ref_clk
`timescale 1ns/1ps
module psa_debounce (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic tick,
    input wire logic raw,
    input wire logic [19:0] limit,
    output logic level
);

psa_pkg::psa_deb_type r;
psa_pkg::psa_deb_type n;

// a glitch back to the held level restarts the stability window
always_comb begin
    n = r;
    if (ce && tick) begin
        if (raw == r.level) begin
            n.cnt = 20'h00000;
        end else if (r.cnt + 20'h00001 >= limit) begin // R20
            n.level = raw;
            n.cnt = 20'h00000;
        end else begin
            n.cnt = r.cnt + 20'h00001;
        end
    end
end

always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        r <= '0;
    end else begin
        r <= n;
    end
end

assign level = r.level;

only_on_tick_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R20
    !(ce && tick) |=> $stable(r.level)) else $error("debounced level moved off tick");

endmodule

// ==== verilog/psa_arbiter.sv ====
// psa_arbiter: power state request arbiter with APB register slave
// assumes: an embedded sequencer answers seq_start with one seq_done pulse
`timescale 1ns/1ps
`include "psa_consts.svh"
module psa_arbiter #(
    parameter logic [19:0] SWOFF_UNIT_TICKS = 20'(`PSA_SWOFF_UNIT_S * `PSA_SLOW_HZ),
    parameter logic [19:0] LONG_PRESS_TICKS = 20'(`PSA_LONG_PRESS_S * `PSA_SLOW_HZ)
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_on_button_n,
    input wire logic power_keep_pin,
    input wire logic power_off_pin,
    input wire logic die_overtemp_flag,
    input wire logic supply_high_ok,
    input wire logic supply_low_fault,
    input wire logic sleep_control_pin_n,
    input wire logic [7:0] irq_events,
    input wire logic irq_pending,
    input wire logic wdog_timeout,
    input wire logic thermal_shutdown,
    input wire logic adc_monitor_shutdown,
    input wire logic seq_done,
    output logic seq_start,
    output psa_pkg::psa_seq_type seq_kind,
    output logic reset_req,
    output logic reset_hard,
    output logic [1:0] power_state
);

psa_pkg::psa_main_type r;
psa_pkg::psa_main_type n;

// ----------------------------------------
// pin filters
// ----------------------------------------
logic [2:0] raw_w;
logic [2:0] deb_w;
logic [19:0] lim_w [3];

assign raw_w = {!sleep_control_pin_n, power_keep_pin, !power_on_button_n};
assign lim_w[0] = LONG_PRESS_TICKS;
assign lim_w[1] = 20'(`PSA_KEEP_DB_TICKS);
assign lim_w[2] = 20'(`PSA_SLEEP_DB_TICKS);

genvar gi;
generate
    for (gi = 0; gi < 3; gi++) begin : g_deb
        psa_debounce u_deb (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .ce(ce),
            .tick(r.tick),
            .raw(raw_w[gi]),
            .limit(lim_w[gi]),
            .level(deb_w[gi])
        );
    end
endgenerate

// ----------------------------------------
// request terms
// ----------------------------------------
logic offpin_act;
logic gate;
logic on_req;
logic keep_off;
logic off_hard_src;
logic off_fast;
logic off_dly;
logic off_src;
logic keep_only;
logic [19:0] dly_ticks;

assign offpin_act = r.offpin_pol ? power_off_pin : !power_off_pin;
assign gate = !supply_high_ok || die_overtemp_flag || offpin_act; // R2 R3
assign on_req = !power_on_button_n || deb_w[1] || |(r.irq_evt & r.irq_on_en); // R4
assign keep_off = r.hold_armed && !r.keep_on && !deb_w[1]; // R13
assign off_hard_src = thermal_shutdown || supply_low_fault || r.restart_req;
assign off_fast = off_hard_src || keep_off;
// watchdog timeout only counts once software has enabled it
assign off_dly = deb_w[0] || offpin_act || (r.wd_en && wdog_timeout) // R12
    || (r.adc_en && adc_monitor_shutdown);
assign off_src = off_hard_src || off_dly;
assign keep_only = keep_off && !off_hard_src;

always_comb begin
    case (r.dly_sel) // R8
        2'h0: dly_ticks = 20'h00000;
        2'h1: dly_ticks = SWOFF_UNIT_TICKS;
        2'h2: dly_ticks = 20'(SWOFF_UNIT_TICKS << 1);
        default: dly_ticks = 20'(SWOFF_UNIT_TICKS << 2);
    endcase
end

// ----------------------------------------
// sequence launch helpers
// ----------------------------------------
function automatic psa_pkg::psa_main_type start_seq(input psa_pkg::psa_main_type s,
        input psa_pkg::psa_seq_type k);
    psa_pkg::psa_main_type o;
    o = s;
    o.st = psa_pkg::psa_st_seq;
    o.kind = k;
    o.seq_start = 1'b1;
    return o;
endfunction

// the off kind follows the settled state, so delay keeps its origin
function automatic psa_pkg::psa_main_type go_off(input psa_pkg::psa_main_type s,
        input logic hard, input logic rstrt);
    psa_pkg::psa_main_type o;
    o = start_seq(s, (s.pstate == `PSA_PS_SLEEP) ? psa_pkg::psa_q_slp_off // R5
        : psa_pkg::psa_q_act_off);
    o.rst_req = 1'b1;
    o.rst_hard = hard; // R9
    o.off_restart = rstrt;
    o.restart_req = 1'b0;
    o.hold_armed = 1'b0;
    return o;
endfunction

// ----------------------------------------
// next state
// ----------------------------------------
logic wr_fire;
logic bad_addr;
logic [31:0] rd_val;

assign wr_fire = psel && penable && pwrite && r.rd_ok;
assign bad_addr = !(paddr == `PSA_REG_CTRL || paddr == `PSA_REG_CFG
    || paddr == `PSA_REG_WDOG || paddr == `PSA_REG_STATUS);

always_comb begin
    rd_val = 32'h00000000;
    case (paddr)
        `PSA_REG_CTRL: rd_val[`PSA_CTRL_KEEP_BIT] = r.keep_on;
        `PSA_REG_CFG: begin
            rd_val[`PSA_CFG_DLY_LSB +: 2] = r.dly_sel;
            rd_val[`PSA_CFG_HARD_BIT] = r.cfg_hard;
            rd_val[`PSA_CFG_RESTART_BIT] = r.cfg_restart;
            rd_val[`PSA_CFG_SLEEP_EN_BIT] = r.sleep_en;
            rd_val[`PSA_CFG_ADC_EN_BIT] = r.adc_en;
            rd_val[`PSA_CFG_OFFPOL_BIT] = r.offpin_pol;
            rd_val[`PSA_CFG_IRQ_LSB +: 8] = r.irq_on_en;
        end
        `PSA_REG_WDOG: begin
            rd_val[`PSA_WDOG_EN_BIT] = r.wd_en;
            rd_val[`PSA_WDOG_LOCK_BIT] = r.wd_lock;
        end
        `PSA_REG_STATUS: rd_val = {22'h000000, r.off_block, r.rst_hard, r.kind, r.st, r.pstate};
        default: rd_val = 32'h00000000;
    endcase
end

always_comb begin
    n = r;
    n.seq_start = 1'b0;
    n.rst_req = 1'b0;
    n.tick = 1'b0;
    if (ce) begin
        if (r.div == 12'(`PSA_SLOW_DIV - 1)) begin // R19
            n.div = 12'h000;
            n.tick = 1'b1;
        end else begin
            n.div = r.div + 12'h001;
        end
        // request decisions happen only on the slow tick; seq_done is taken on any cycle
        if (r.tick) begin
            n.irq_evt = 8'h00;
            case (r.st)
                psa_pkg::psa_st_off: begin
                    if (!off_src) begin
                        n.off_block = 1'b0; // R7
                    end
                    if (!r.off_block && on_req && !gate) begin // R1 R2 R3
                        n = start_seq(n, psa_pkg::psa_q_off_act);
                    end
                end
                psa_pkg::psa_st_act, psa_pkg::psa_st_slp: begin
                    if (off_fast) begin // R6
                        n = go_off(n, keep_only ? 1'b0 : r.cfg_hard,
                            keep_only ? 1'b0 : r.cfg_restart);
                    end else if (off_dly) begin
                        if (dly_ticks == 20'h00000) begin
                            n = go_off(n, r.cfg_hard, r.cfg_restart);
                        end else begin
                            n.st = psa_pkg::psa_st_dly; // R8
                            n.dly = dly_ticks;
                        end
                    end else if (r.st == psa_pkg::psa_st_act) begin
                        if (r.keep_on || deb_w[1]) begin
                            n.hold_armed = 1'b1;
                        end
                        if (r.sleep_en && deb_w[2] && !irq_pending) begin // R14 R15
                            n = start_seq(n, psa_pkg::psa_q_act_slp);
                        end
                    end else if (!deb_w[2] || |r.irq_evt) begin // R16 R17
                        n = start_seq(n, psa_pkg::psa_q_slp_act);
                    end
                end
                psa_pkg::psa_st_dly: begin
                    if (off_fast) begin
                        n = go_off(n, keep_only ? 1'b0 : r.cfg_hard,
                            keep_only ? 1'b0 : r.cfg_restart);
                    end else if (r.dly <= 20'h00001) begin
                        n = go_off(n, r.cfg_hard, r.cfg_restart);
                    end else begin
                        n.dly = r.dly - 20'h00001;
                    end
                end
                default: begin
                end
            endcase
        end
        if (r.st == psa_pkg::psa_st_seq && seq_done) begin // R18
            case (r.kind)
                psa_pkg::psa_q_off_act, psa_pkg::psa_q_slp_act: begin
                    n.st = psa_pkg::psa_st_act;
                    n.pstate = `PSA_PS_ACTIVE;
                end
                psa_pkg::psa_q_act_slp: begin
                    n.st = psa_pkg::psa_st_slp;
                    n.pstate = `PSA_PS_SLEEP;
                end
                default: begin
                    n.pstate = `PSA_PS_OFF;
                    if (r.off_restart && !gate) begin // R11
                        n = start_seq(n, psa_pkg::psa_q_off_act);
                    end else begin
                        n.st = psa_pkg::psa_st_off; // R10
                        n.off_block = !r.off_restart;
                    end
                end
            endcase
        end
        // set after the tick clear so a same-cycle event survives
        n.irq_evt = n.irq_evt | irq_events;
        n.rd_ok = psel && !(penable && r.rd_ok);
        if (psel && !pwrite) begin
            n.prdata = rd_val;
        end
        if (wr_fire) begin
            case (paddr)
                `PSA_REG_CTRL: begin
                    n.keep_on = pwdata[`PSA_CTRL_KEEP_BIT];
                    if (pwdata[`PSA_CTRL_RESTART_BIT]) begin
                        n.restart_req = 1'b1;
                    end
                end
                `PSA_REG_CFG: begin
                    n.dly_sel = pwdata[`PSA_CFG_DLY_LSB +: 2];
                    n.cfg_hard = pwdata[`PSA_CFG_HARD_BIT];
                    n.cfg_restart = pwdata[`PSA_CFG_RESTART_BIT];
                    n.sleep_en = pwdata[`PSA_CFG_SLEEP_EN_BIT];
                    n.adc_en = pwdata[`PSA_CFG_ADC_EN_BIT];
                    n.offpin_pol = pwdata[`PSA_CFG_OFFPOL_BIT];
                    n.irq_on_en = pwdata[`PSA_CFG_IRQ_LSB +: 8];
                end
                `PSA_REG_WDOG: begin
                    if (!r.wd_lock) begin // R12
                        n.wd_en = pwdata[`PSA_WDOG_EN_BIT];
                        n.wd_lock = pwdata[`PSA_WDOG_LOCK_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end
end

always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        r <= `PSA_REG_RST == 32'h00000000 ? '0 : '0;
    end else begin
        r <= n;
    end
end

assign prdata = r.prdata;
assign pready = ce && r.rd_ok;
assign pslverr = ce && r.rd_ok && penable && bad_addr;
assign seq_start = r.seq_start;
assign seq_kind = r.kind;
assign reset_req = r.rst_req;
assign reset_hard = r.rst_hard;
assign power_state = r.pstate;

// ----------------------------------------
// checks
// ----------------------------------------
default clocking dc @(posedge ref_clk);
endclocking
default disable iff (!nrst);

sequence arb_tick_s;
    ce && r.tick;
endsequence
sequence off_eval_s;
    arb_tick_s ##0 (r.st == psa_pkg::psa_st_off);
endsequence
sequence up_eval_s;
    arb_tick_s ##0 (r.st == psa_pkg::psa_st_act || r.st == psa_pkg::psa_st_slp);
endsequence

on_start_a: assert property (off_eval_s ##0 (!r.off_block && on_req && !gate) // R1
    |=> r.seq_start && r.kind == psa_pkg::psa_q_off_act) else $error("on not started");
hot_gate_a: assert property (off_eval_s ##0 die_overtemp_flag // R3
    |=> r.st == psa_pkg::psa_st_off && !r.seq_start) else $error("on passed overtemp");
irq_on_a: assert property (off_eval_s ##0 (!r.off_block && !gate && |(r.irq_evt & r.irq_on_en)) // R4
    |=> r.kind == psa_pkg::psa_q_off_act) else $error("interrupt on ignored");
off_prio_a: assert property (up_eval_s ##0 off_fast // R6
    |=> r.seq_start && r.rst_req && r.kind != psa_pkg::psa_q_act_slp
    && r.kind != psa_pkg::psa_q_slp_act) else $error("off lost priority");
off_block_a: assert property (off_eval_s ##0 r.off_block // R7
    |=> !r.seq_start) else $error("on while off held");
delay_load_a: assert property (up_eval_s ##0 (!off_fast && off_dly && r.dly_sel == 2'h1) // R8
    |=> r.st == psa_pkg::psa_st_dly && r.dly == SWOFF_UNIT_TICKS) else $error("delay bad");
restart_a: assert property (ce && seq_done && r.st == psa_pkg::psa_st_seq // R11
    && r.off_restart && !gate && (r.kind == psa_pkg::psa_q_act_off
    || r.kind == psa_pkg::psa_q_slp_off)
    |=> r.seq_start && r.kind == psa_pkg::psa_q_off_act) else $error("no cold restart");
wd_lock_a: assert property (r.wd_lock |=> r.wd_lock && $stable(r.wd_en)) // R12
    else $error("locked watchdog changed");
keep_pair_a: assert property (up_eval_s ##0 (r.keep_on || deb_w[1]) && !off_src // R13
    |=> !r.rst_req) else $error("off while kept on");
sleep_irq_a: assert property (up_eval_s ##0 irq_pending && !off_src // R15
    |=> !(r.seq_start && r.kind == psa_pkg::psa_q_act_slp)) else $error("slept with irq");
wake_src_a: assert property (r.seq_start && r.kind == psa_pkg::psa_q_slp_act // R17
    |-> $past(r.st) == psa_pkg::psa_st_slp) else $error("wake outside sleep");
tick_gap_a: assert property (arb_tick_s |=> !r.tick [*8]) // R19
    else $error("tick too frequent");

endmodule

// ==== tb/psa_seq_model.sv ====
// psa_seq_model: behavioural sequencer, answers each start with one done pulse
// assumes: seq_start is a one-cycle pulse, lat is set by the bench
`timescale 1ns/1ps
module psa_seq_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic seq_start,
    input wire logic [7:0] lat,
    output logic seq_done
);
    logic [7:0] cnt_reg;
    logic busy_reg;

    // done never shares a cycle with start, even for lat of zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
            seq_done <= 1'b0;
        end else begin
            seq_done <= 1'b0;
            if (seq_start) begin
                busy_reg <= 1'b1;
                cnt_reg <= lat;
            end else if (busy_reg) begin
                if (cnt_reg == 8'h00) begin
                    busy_reg <= 1'b0;
                    seq_done <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 8'h01;
                end
            end
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// tb_top: register and request scenarios for the power state arbiter
// assumes: shortened delay counts, slow tick every 3125 clocks
`timescale 1ns/1ps
module tb_top;
    localparam int tick_cyc = 3125;
    logic ref_clk, nrst, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, irq_events, lat;
    logic [31:0] pwdata, prdata, rd;
    logic power_on_button_n, power_keep_pin, power_off_pin, die_overtemp_flag;
    logic supply_high_ok, supply_low_fault, sleep_control_pin_n, irq_pending;
    logic wdog_timeout, thermal_shutdown, adc_monitor_shutdown;
    logic seq_done, seq_start, reset_req, reset_hard, er, rr;
    psa_pkg::psa_seq_type seq_kind;
    logic [1:0] power_state;
    int fails, checked, cyc;

    psa_arbiter #(.SWOFF_UNIT_TICKS(20'h00004), .LONG_PRESS_TICKS(20'h00003)) i_psa_arbiter (
        .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_on_button_n(power_on_button_n),
        .power_keep_pin(power_keep_pin), .power_off_pin(power_off_pin),
        .die_overtemp_flag(die_overtemp_flag), .supply_high_ok(supply_high_ok),
        .supply_low_fault(supply_low_fault), .sleep_control_pin_n(sleep_control_pin_n),
        .irq_events(irq_events), .irq_pending(irq_pending), .wdog_timeout(wdog_timeout),
        .thermal_shutdown(thermal_shutdown), .adc_monitor_shutdown(adc_monitor_shutdown),
        .seq_done(seq_done), .seq_start(seq_start), .seq_kind(seq_kind),
        .reset_req(reset_req), .reset_hard(reset_hard), .power_state(power_state)
    );

    psa_seq_model i_psa_seq_model (
        .ref_clk(ref_clk), .nrst(nrst), .seq_start(seq_start), .lat(lat),
        .seq_done(seq_done)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // bench tasks
    // ----------------------------------------
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // request held until pready is seen high; data taken at that same edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // only the watchdog process ends a wait that never gets an answer
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic ticks(input int n);
        repeat (n * tick_cyc) @(posedge ref_clk);
    endtask

    task automatic irq_pulse;
        @(posedge ref_clk);
        irq_events <= 8'h01;
        @(posedge ref_clk);
        irq_events <= 8'h00;
    endtask

    // waits for a sequence start, checks its kind, returns wait and reset pulse
    task automatic wait_seq(input psa_pkg::psa_seq_type k, output int n, output logic r);
        n = 0;
        r = 1'b0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (seq_start !== 1'b1 && n < 8 * tick_cyc);
        r = reset_req;
        chk("seq_start", 32'h00000001, 32'(seq_start));
        chk("seq_kind", 32'(k), 32'(seq_kind));
    endtask

    task automatic state_is(input logic [1:0] s);
        chk("power_state", 32'(s), 32'(power_state));
    endtask

    initial begin
        repeat (90000) @(posedge ref_clk);
        fails++;
        wrap_up();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, irq_pending, wdog_timeout} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        irq_events = 8'h00;
        lat = 8'h14;
        // off pin resets to active low, so it idles high
        {power_keep_pin, power_off_pin, die_overtemp_flag, supply_low_fault} = 4'h4;
        {thermal_shutdown, adc_monitor_shutdown} = 2'h0;
        {power_on_button_n, supply_high_ok, sleep_control_pin_n} = 3'h7;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h00000000, rd, er);
            chk("register reset value", 32'h00000000, rd);
        end
        apb(1'b0, 8'h10, 32'h00000000, rd, er);
        chk("unmapped error", 32'h00000001, 32'(er));
        $display("test registers done");

        // gated event first, then a plain button press
        wr(8'h04, 32'h00000100);
        die_overtemp_flag <= 1'b1;
        irq_pulse();
        ticks(2);
        state_is(2'h0);
        chk("seq_kind idle", 32'h00000000, 32'(seq_kind));
        die_overtemp_flag <= 1'b0;
        power_on_button_n <= 1'b0;
        wait_seq(psa_pkg::psa_q_off_act, cyc, rr);
        power_on_button_n <= 1'b1;
        repeat (40) @(posedge ref_clk);
        state_is(2'h1);
        $display("test power on done");

        // sleep held off by pending interrupt, then sleep and wake, slow sequencer
        wr(8'h04, 32'h00000110);
        sleep_control_pin_n <= 1'b0;
        irq_pending <= 1'b1;
        lat <= 8'hC8;
        ticks(4);
        state_is(2'h1);
        irq_pending <= 1'b0;
        wait_seq(psa_pkg::psa_q_act_slp, cyc, rr);
        repeat (250) @(posedge ref_clk);
        state_is(2'h2);
        irq_pulse();
        wait_seq(psa_pkg::psa_q_slp_act, cyc, rr);
        sleep_control_pin_n <= 1'b1;
        repeat (250) @(posedge ref_clk);
        state_is(2'h1);
        lat <= 8'h14;
        $display("test sleep done");

        // keep bit released: soft depth shutdown even with hard depth configured
        wr(8'h04, 32'h00000104);
        wr(8'h00, 32'h00000001);
        ticks(1);
        wr(8'h00, 32'h00000000);
        wait_seq(psa_pkg::psa_q_act_off, cyc, rr);
        chk("reset_req", 32'h00000001, 32'(rr));
        repeat (40) @(posedge ref_clk);
        chk("reset_hard", 32'h00000000, 32'(reset_hard));
        ticks(2);
        state_is(2'h0);
        irq_pulse();
        wait_seq(psa_pkg::psa_q_off_act, cyc, rr);
        repeat (40) @(posedge ref_clk);
        state_is(2'h1);
        $display("test keep release done");

        // immediate thermal off with cold restart and hard depth
        wr(8'h04, 32'h0000010C);
        thermal_shutdown <= 1'b1;
        wait_seq(psa_pkg::psa_q_act_off, cyc, rr);
        thermal_shutdown <= 1'b0;
        chk("reset_req", 32'h00000001, 32'(rr));
        wait_seq(psa_pkg::psa_q_off_act, cyc, rr);
        chk("reset_hard", 32'h00000001, 32'(reset_hard));
        repeat (40) @(posedge ref_clk);
        state_is(2'h1);
        $display("test cold restart done");

        // watchdog ignored while disabled, lock holds, delayed off of one unit
        wr(8'h04, 32'h00000101);
        wdog_timeout <= 1'b1;
        ticks(1);
        state_is(2'h1);
        wr(8'h08, 32'h00000003);
        wr(8'h08, 32'h00000000);
        apb(1'b0, 8'h08, 32'h00000000, rd, er);
        chk("watchdog lock", 32'h00000003, rd);
        wait_seq(psa_pkg::psa_q_act_off, cyc, rr);
        chk("delay floor", 32'h00000001, 32'(cyc >= 3 * tick_cyc));
        chk("delay ceiling", 32'h00000001, 32'(cyc <= 5 * tick_cyc + 20));
        wdog_timeout <= 1'b0;
        repeat (40) @(posedge ref_clk);
        state_is(2'h0);
        $display("test watchdog done");
        wrap_up();
    end
endmodule
